// file: core/dep_row_programmer.sv
// Data EEPROM row programmer: read path, row latches, timed program
// cycle, wait/halt handling and read-out protection options.
// Assumes the CPU memory bus and register port run on clk.
//
// Notes on behaviour
// - Window clear: reads behave like plain ROM
// - Window set: writes fill 32 byte latches
// - Go programs all captured bytes together
// - Row comes from the last captured write
// - Cycle end clears go and window together
// - Latches clear at end or window fall
// - Latch contents can never be read
// - Reads with window set leave bus undriven
// - Writes with window clear are dropped
// - Cycle length is timed in hardware
// - Wait entered now, or after running cycle
// - Halt stops at once, abandons the cycle
// - Reset aborts a running cycle
// - One protect bit blocks readout and rewrite
// - Protect removal erases program memory and EEPROM
// - Write/erase lock holds until reset reloads the strap
// - Window clear ignored while go is set
// - Control register: window bit1, go bit0
// - Clearing go cuts the cycle short
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module dep_row_programmer #(
   parameter logic [15:0] PROG_CYCLES = dep_pkg::PROG_CYCLES_DEF
) (
   // Clock, reset, clock enable
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   // CPU memory bus to the EEPROM area
   input  wire logic [dep_pkg::ADDR_W-1:0] mem_addr,
   input  wire logic [dep_pkg::DATA_W-1:0] mem_wdata,
   input  wire logic                      mem_wr,
   input  wire logic                      mem_rd,
   output logic      [dep_pkg::DATA_W-1:0] mem_rdata,
   output logic                           mem_rdata_oe,
   // Register port
   input  wire logic [dep_pkg::RADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   // External read-out port
   input  wire logic [dep_pkg::ADDR_W-1:0] ext_addr,
   input  wire logic                      ext_rd,
   output logic      [dep_pkg::DATA_W-1:0] ext_rdata,
   output logic                           ext_rd_ok,
   // Option byte values and program memory controls
   input  wire logic                      opt_rp_strap,
   input  wire logic                      opt_we_strap,
   output logic                           prog_read_block,
   output logic                           prog_write_block,
   output logic                           prog_mem_erase,
   // Power modes
   input  wire logic                      wfi_req,
   input  wire logic                      halt_req,
   output logic                           eep_in_wait,
   output logic                           eep_in_halt
);
   import dep_pkg::*;

   localparam int ROW_W = ADDR_W - COL_W;

   dep_arr_if a ();

   dep_state_t                   st_r, st_nxt;
   logic                         go_r, go_nxt;
   logic                         win_r, win_nxt;
   logic [DATA_W-1:0]            lat_r [0:ROW_BYTES-1];
   logic [ROW_BYTES-1:0]         mask_r;
   logic [ROW_W-1:0]             row_r;
   logic [CNT_W-1:0]             cnt_r;
   logic                         rp_r, we_r, opt_loaded_r;
   logic                         mem_rd_r, ext_rd_r;
   logic                         csr_wr, opt_wr, capture, done, erase;
   logic                         lat_clear;

   function automatic logic reg_hit(input logic [RADDR_W-1:0] ad,
                                    input logic [1:0] ofs);
      reg_hit = (ad == ofs);
   endfunction

   function automatic logic [COL_W-1:0] col_of(input logic [ADDR_W-1:0] ad);
      col_of = ad[COL_W-1:0];
   endfunction

   function automatic logic [ROW_W-1:0] row_of(input logic [ADDR_W-1:0] ad);
      row_of = ad[ADDR_W-1:COL_W];
   endfunction

   assign csr_wr  = reg_wr && reg_hit(reg_addr, CSR_OFS) &&
                    (st_r == DEP_IDLE || st_r == DEP_PROG);
   assign opt_wr  = reg_wr && reg_hit(reg_addr, OPT_OFS) && opt_loaded_r;
   // Writes while a cycle runs would corrupt the row being programmed
   assign capture = mem_wr && win_r && !go_r && st_r == DEP_IDLE;
   assign done    = st_r == DEP_PROG && go_r &&
                    cnt_r == PROG_CYCLES - 16'h0001;
   assign erase   = opt_wr && rp_r && !reg_wdata[OPT_RP_BIT];

   // Control/status bit next values
   always_comb begin
      go_nxt  = go_r;
      win_nxt = win_r;
      if (csr_wr) begin
         if (reg_wdata[CSR_WIN_BIT]) begin
            win_nxt = 1'b1;
         end else if (!go_r) begin
            win_nxt = 1'b0;
         end
         if (!reg_wdata[CSR_GO_BIT]) begin
            go_nxt = 1'b0;
         end else if (win_r || reg_wdata[CSR_WIN_BIT]) begin
            go_nxt = 1'b1;
         end
      end
      if (done || st_nxt == DEP_HALT || erase) begin
         go_nxt  = 1'b0;
         win_nxt = 1'b0;
      end
   end

   // Power mode and cycle sequencing
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         DEP_IDLE: begin
            // A go not yet running already counts as a cycle in progress
            if (go_r) begin
               st_nxt = DEP_PROG;
            end else if (wfi_req) begin
               st_nxt = DEP_WAIT;
            end
         end
         DEP_PROG: begin
            if (done) begin
               st_nxt = wfi_req ? DEP_WAIT : DEP_IDLE;
            end else if (!go_r) begin
               st_nxt = DEP_IDLE;
            end
         end
         DEP_WAIT: begin
            if (!wfi_req) begin
               st_nxt = DEP_IDLE;
            end
         end
         DEP_HALT: begin
            if (!halt_req) begin
               st_nxt = DEP_IDLE;
            end
         end
         default: st_nxt = DEP_IDLE;
      endcase
      // Halt overrides every state and abandons the row
      if (halt_req) begin
         st_nxt = DEP_HALT;
      end
   end

   // Reset returns to idle with no cycle; the row is left as is
   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= DEP_IDLE;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         go_r <= CSR_RST[CSR_GO_BIT];
      end else if (ce) begin
         go_r <= go_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         win_r <= CSR_RST[CSR_WIN_BIT];
      end else if (ce) begin
         win_r <= win_nxt;
      end
   end

   // Any stop of the cycle restarts the count from zero
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (st_r == DEP_PROG && go_r && !done) begin
            cnt_r <= cnt_r + 16'h0001;
         end else begin
            cnt_r <= '0;
         end
      end
   end

   // A repeat write ANDs into the latch, as over-programming does
   assign lat_clear = done || (win_r && !win_nxt);

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < ROW_BYTES; i++) begin
            lat_r[i] <= ERASED;
         end
      end else if (ce) begin
         if (lat_clear) begin
            for (int i = 0; i < ROW_BYTES; i++) begin
               lat_r[i] <= ERASED;
            end
         end else if (capture) begin
            lat_r[col_of(mem_addr)] <=
               lat_r[col_of(mem_addr)] & mem_wdata;
         end
      end
   end

   // Column and row bookkeeping for the row write
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r <= '0;
         row_r  <= '0;
      end else if (ce) begin
         if (lat_clear) begin
            mask_r <= '0;
         end else if (capture) begin
            mask_r[col_of(mem_addr)] <= 1'b1;
            row_r                    <= row_of(mem_addr);
         end
      end
   end

   // Option bits: loaded once after reset, protect removal erases
   always_ff @(posedge clk) begin
      if (rst) begin
         opt_loaded_r <= 1'b0;
      end else if (ce) begin
         opt_loaded_r <= 1'b1;
      end
   end

   // Protect takes the option byte once after reset and keeps it until software rewrites it
   always_ff @(posedge clk) begin
      if (rst) begin
         rp_r <= 1'b0;
      end else if (ce) begin
         if (!opt_loaded_r) begin
            rp_r <= opt_rp_strap;
         end else if (opt_wr) begin
            rp_r <= reg_wdata[OPT_RP_BIT];
         end
      end
   end

   // Set only: a write of zero leaves the lock in place
   always_ff @(posedge clk) begin
      if (rst) begin
         we_r <= 1'b0;
      end else if (ce) begin
         if (!opt_loaded_r) begin
            we_r <= opt_we_strap;
         end else if (opt_wr && reg_wdata[OPT_WE_BIT]) begin
            we_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prog_mem_erase <= 1'b0;
      end else if (ce) begin
         prog_mem_erase <= erase;
      end
   end

   // Only the program memory is locked by the write/erase option
   assign prog_read_block  = rp_r;
   assign prog_write_block = rp_r || we_r;

   // Array connection: all captured bytes go in one row write
   assign a.ce        = ce;
   assign a.row_wr    = done;
   assign a.row       = row_r;
   assign a.row_mask  = mask_r;
   assign a.erase_all = erase;
   assign a.rd_addr   = mem_addr;
   assign a.xrd_addr  = ext_addr;
   always_comb begin
      a.row_data = '0;
      for (int i = 0; i < ROW_BYTES; i++) begin
         a.row_data[i*DATA_W +: DATA_W] = lat_r[i];
      end
   end

   dep_cell_array u_cells (
      .clk (clk),
      .a   (a)
   );

   // Read strobes delayed to the data cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_rd_r <= 1'b0;
      end else if (ce) begin
         mem_rd_r <= mem_rd && !win_r;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ext_rd_r <= 1'b0;
      end else if (ce) begin
         ext_rd_r <= ext_rd && !rp_r;
      end
   end

   // Cell data only; latches have no path to the bus
   assign mem_rdata    = mem_rd_r ? a.rd_data : '0;
   assign mem_rdata_oe = mem_rd_r;
   assign ext_rdata    = ext_rd_r ? a.xrd_data : '0;
   assign ext_rd_ok    = ext_rd_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         if (reg_rd && reg_hit(reg_addr, CSR_OFS)) begin
            reg_rdata <= {6'h00, win_r, go_r};
         end else if (reg_rd && reg_hit(reg_addr, OPT_OFS)) begin
            reg_rdata <= {6'h00, we_r, rp_r};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   assign eep_in_wait = st_r == DEP_WAIT;
   assign eep_in_halt = st_r == DEP_HALT;
endmodule

// file: core/dep_pkg.sv
// Constants and types shared by the data EEPROM row programmer.
// Assumes an 8-bit CPU data bus and a small register port.
package dep_pkg;
   localparam int DATA_W    = 8;
   localparam int ROW_BYTES = 32;
   localparam int COL_W     = 5;
   localparam int MEM_BYTES = 128;
   localparam int ADDR_W    = 7;
   localparam int RADDR_W   = 2;
   localparam int CNT_W     = 16;
   // Register offsets on the register port
   localparam logic [1:0] CSR_OFS = 2'h0;
   localparam logic [1:0] OPT_OFS = 2'h1;
   // Control/status register fields
   localparam int CSR_GO_BIT  = 0;
   localparam int CSR_WIN_BIT = 1;
   localparam logic [7:0] CSR_RST = 8'h00;
   // Option register fields
   localparam int OPT_RP_BIT = 0;
   localparam int OPT_WE_BIT = 1;
   // Default programming cycle length in system clocks
   localparam logic [15:0] PROG_CYCLES_DEF = 16'h03E8;
   // Value of an erased cell and of a cleared latch
   localparam logic [7:0] ERASED = 8'hFF;
   typedef enum logic [3:0] {
      DEP_IDLE = 4'b0001,
      DEP_PROG = 4'b0010,
      DEP_WAIT = 4'b0100,
      DEP_HALT = 4'b1000
   } dep_state_t;
endpackage

// file: core/dep_arr_if.sv
// Connection between the row programmer and its cell array.
// Assumes both ends share clk; ce freezes the array as well.
`timescale 1ns/100ps
interface dep_arr_if;
   import dep_pkg::*;
   logic                          ce;
   logic                          row_wr;
   logic [ADDR_W-COL_W-1:0]       row;
   logic [ROW_BYTES*DATA_W-1:0]   row_data;
   logic [ROW_BYTES-1:0]          row_mask;
   logic                          erase_all;
   logic [ADDR_W-1:0]             rd_addr;
   logic [DATA_W-1:0]             rd_data;
   logic [ADDR_W-1:0]             xrd_addr;
   logic [DATA_W-1:0]             xrd_data;
   modport ctrl (output ce, row_wr, row, row_data, row_mask, erase_all,
                 output rd_addr, xrd_addr, input rd_data, xrd_data);
   modport arr  (input ce, row_wr, row, row_data, row_mask, erase_all,
                 input rd_addr, xrd_addr, output rd_data, xrd_data);
endinterface

// file: core/dep_cell_array.sv
// Nonvolatile cell array model: row write, mass erase, two read ports.
// Assumes the programmer sequences writes; cells have no reset.
`timescale 1ns/100ps
module dep_cell_array (
   // Clock
   input wire logic clk,
   // Programmer side
   dep_arr_if.arr   a
);
   import dep_pkg::*;

   logic [DATA_W-1:0] cell_r [0:MEM_BYTES-1];

   // Cells keep their contents across reset, as real EEPROM does
   always_ff @(posedge clk) begin
      if (a.ce) begin
         if (a.erase_all) begin
            for (int i = 0; i < MEM_BYTES; i++) begin
               cell_r[i] <= ERASED;
            end
         end else if (a.row_wr) begin
            for (int j = 0; j < ROW_BYTES; j++) begin
               if (a.row_mask[j]) begin
                  cell_r[{a.row, COL_W'(j)}] <=
                     a.row_data[j*DATA_W +: DATA_W];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (a.ce) begin
         a.rd_data  <= cell_r[a.rd_addr];
         a.xrd_data <= cell_r[a.xrd_addr];
      end
   end
endmodule

// file: bench/dep_assertions.sv
// Port-level property checker for the data EEPROM row programmer.
// Assumes one clock domain; the bench drops ce only around one register write.
`timescale 1ns/100ps
module dep_assertions (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         rst,
   // Memory bus
   input wire logic                         mem_rd,
   input wire logic [dep_pkg::DATA_W-1:0]   mem_rdata,
   input wire logic                         mem_rdata_oe,
   // Register port
   input wire logic [dep_pkg::RADDR_W-1:0]  reg_addr,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_rdata,
   // External port and options
   input wire logic                         ext_rd,
   input wire logic                         ext_rd_ok,
   input wire logic                         prog_read_block,
   input wire logic                         prog_write_block,
   input wire logic                         prog_mem_erase,
   // Power modes
   input wire logic                         wfi_req,
   input wire logic                         halt_req,
   input wire logic                         eep_in_wait,
   input wire logic                         eep_in_halt
);
   import dep_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_ext_blk;
      ext_rd && prog_read_block && !reg_wr;
   endsequence
   // Straps load on the first edge after reset, so skip that edge
   sequence s_ext_free;
      ext_rd && !prog_read_block && !reg_wr && !$past(rst);
   endsequence
   property p_oe_cause;
      mem_rdata_oe |-> $past(mem_rd);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("bus driven without a read");
   property p_rd_zero;
      !mem_rdata_oe |-> mem_rdata == 8'h00;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("read data seen while undriven");
   property p_csr_hi;
      $past(reg_rd) && $past(reg_addr) == CSR_OFS |-> reg_rdata[7:2] == 6'h00;
   endproperty
   a_csr_hi: assert property (p_csr_hi)
      else $error("control register upper bits set");
   property p_unmap;
      $past(reg_rd) && $past(reg_addr[1]) |-> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped offset read nonzero");
   property p_ext_blk;
      s_ext_blk |=> !ext_rd_ok;
   endproperty
   a_ext_blk: assert property (p_ext_blk)
      else $error("protected readout allowed");
   property p_ext_ok;
      s_ext_free |=> ext_rd_ok;
   endproperty
   a_ext_ok: assert property (p_ext_ok)
      else $error("unprotected readout refused");
   property p_blk_pair;
      prog_read_block |-> prog_write_block;
   endproperty
   a_blk_pair: assert property (p_blk_pair)
      else $error("protect does not block rewrite");
   property p_erase;
      prog_mem_erase |-> !prog_read_block ##1 !prog_mem_erase;
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase pulse wrong");
   property p_halt;
      halt_req |=> eep_in_halt;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt not entered at once");
   property p_wait_cause;
      eep_in_wait |-> $past(wfi_req);
   endproperty
   a_wait_cause: assert property (p_wait_cause)
      else $error("wait without request");
endmodule

bind dep_row_programmer dep_assertions u_assert (.clk, .rst, .mem_rd,
   .mem_rdata, .mem_rdata_oe, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .ext_rd, .ext_rd_ok, .prog_read_block, .prog_write_block,
   .prog_mem_erase, .wfi_req, .halt_req, .eep_in_wait, .eep_in_halt);

// file: bench/dep_cpu_model.sv
// CPU core model: memory bus and register port master tasks.
// Assumes callers start each task off a clock edge.
`timescale 1ns/100ps
module dep_cpu_model (
   // Clock
   input wire logic                       clk,
   // Memory bus
   output logic [dep_pkg::ADDR_W-1:0]     mem_addr,
   output logic [dep_pkg::DATA_W-1:0]     mem_wdata,
   output logic                           mem_wr,
   output logic                           mem_rd,
   input wire logic [dep_pkg::DATA_W-1:0] mem_rdata,
   input wire logic                       mem_rdata_oe,
   // Register port
   output logic [dep_pkg::RADDR_W-1:0]    reg_addr,
   output logic [7:0]                     reg_wdata,
   output logic                           reg_wr,
   output logic                           reg_rd,
   input wire logic [7:0]                 reg_rdata
);
   import dep_pkg::*;
   // Code is never fetched from the EEPROM, so writes are safe here
   initial begin
      {mem_addr, mem_wdata, mem_wr, mem_rd} = '0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   end
   // Released data shows the inverse so a stale value cannot pass
   task automatic rw(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      {reg_wdata, reg_wr} <= {~v, 1'b0};
   endtask
   task automatic rr(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
      @(posedge clk);
   endtask
   task automatic mw(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk);
      {mem_addr, mem_wdata, mem_wr} <= {a, v, 1'b1};
      @(posedge clk);
      {mem_wdata, mem_wr} <= {~v, 1'b0};
   endtask
   task automatic mr(input logic [6:0] a, output logic [7:0] v,
                     output logic o);
      @(posedge clk);
      {mem_addr, mem_rd} <= {a, 1'b1};
      @(posedge clk);
      mem_rd <= 1'b0;
      @(negedge clk);
      v = mem_rdata;
      o = mem_rdata_oe;
      @(posedge clk);
   endtask
endmodule

// file: bench/dep_row_programmer_tb.sv
// Self-checking bench for the data EEPROM row programmer.
// Assumes dep_cpu_model drives both buses; short program cycle.
`timescale 1ns/100ps
module dep_row_programmer_tb;
   import dep_pkg::*;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic opt_rp_strap = 1'b1, opt_we_strap = 1'b1;
   logic wfi_req = 1'b0, halt_req = 1'b0, ext_rd = 1'b0;
   logic [ADDR_W-1:0] mem_addr, ext_addr = '0;
   logic [DATA_W-1:0] mem_wdata, mem_rdata, ext_rdata;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic mem_wr, mem_rd, mem_rdata_oe, reg_wr, reg_rd, ext_rd_ok, oe;
   logic prog_read_block, prog_write_block, prog_mem_erase;
   logic eep_in_wait, eep_in_halt;
   int n_fail = 0;
   int checked = 0;
   logic [6:0] ra [5] = '{7'h21, 7'h3F, 7'h22, 7'h03, 7'h01};
   logic [7:0] re [5] = '{8'h0A, 8'h33, 8'hFF, 8'hFF, 8'hFF};
   always #10 clk = ~clk;
   dep_row_programmer #(.PROG_CYCLES(16'h0008)) dut (.clk, .rst, .ce,
      .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata, .mem_rdata_oe,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ext_addr,
      .ext_rd, .ext_rdata, .ext_rd_ok, .opt_rp_strap, .opt_we_strap,
      .prog_read_block, .prog_write_block, .prog_mem_erase, .wfi_req,
      .halt_req, .eep_in_wait, .eep_in_halt);
   dep_cpu_model cpu (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
      .mem_rdata, .mem_rdata_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata);
   task automatic chk(input string nm, input logic [7:0] s, e);
      checked++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic rdm(input logic [6:0] a, input logic [7:0] e);
      cpu.mr(a, d, oe);
      chk("mem_oe", {7'h0, oe}, 8'h01);
      chk("mem", d, e);
   endtask
   task automatic idle;
      int n;
      n = 0;
      d = 8'h01;
      while (d !== 8'h00 && n < 9) begin
         cpu.rr(CSR_OFS, d);
         n++;
      end
      chk("csr_end", d, CSR_RST);
      chk("cyc_len", (n > 1 && n < 5) ? 8'h01 : 8'h00, 8'h01);
   endtask
   task automatic prog(input logic [6:0] a, input logic [7:0] v);
      cpu.rw(CSR_OFS, 8'h02);
      cpu.mw(a, v);
   endtask
   task automatic go;
      cpu.rw(CSR_OFS, 8'h03);
   endtask
   task automatic ext(input logic [7:0] e);
      @(posedge clk);
      ext_rd <= 1'b1;
      @(posedge clk);
      ext_rd <= 1'b0;
      @(negedge clk);
      chk("ext_ok", {7'h0, ext_rd_ok}, e);
      chk("ext_data", ext_rdata, e[0] ? ERASED : 8'h00);
      @(posedge clk);
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cpu.rr(CSR_OFS, d);
      chk("csr_rst", d, CSR_RST);
      cpu.rr(2'h2, d);
      chk("unmapped", d, 8'h00);
      ce <= 1'b0;
      cpu.rw(CSR_OFS, 8'h02);
      ce <= 1'b1;
      cpu.rr(CSR_OFS, d);
      chk("csr_frozen", d, CSR_RST);
      cpu.rr(OPT_OFS, d);
      chk("opt", d, 8'h03);
      ext(8'h00);
      cpu.rw(OPT_OFS, 8'h00);
      @(negedge clk);
      chk("erase_pulse", {7'h0, prog_mem_erase}, 8'h01);
      chk("rblock", {7'h0, prog_read_block}, 8'h00);
      cpu.rr(OPT_OFS, d);
      chk("opt_lock", d, 8'h02);
      chk("wblock", {7'h0, prog_write_block}, 8'h01);
      ext(8'h01);
      rdm(7'h01, ERASED);
      cpu.mw(7'h03, 8'h00);
      prog(7'h21, 8'h5A);
      cpu.mr(7'h21, d, oe);
      chk("oe_win", {7'h0, oe}, 8'h00);
      chk("latch_rd", d, 8'h00);
      cpu.mw(7'h21, 8'h0F);
      cpu.mw(7'h3F, 8'h33);
      go;
      cpu.rw(CSR_OFS, 8'h01);
      cpu.rr(CSR_OFS, d);
      chk("csr_go", d, 8'h03);
      idle;
      for (int i = 0; i < 5; i++) rdm(ra[i], re[i]);
      prog(7'h04, 8'h11);
      cpu.mw(7'h45, 8'h22);
      go;
      idle;
      rdm(7'h44, 8'h11);
      rdm(7'h45, 8'h22);
      rdm(7'h04, ERASED);
      prog(7'h50, 8'h00);
      cpu.rw(CSR_OFS, 8'h00);
      prog(7'h51, 8'h77);
      go;
      idle;
      rdm(7'h50, ERASED);
      rdm(7'h51, 8'h77);
      prog(7'h60, 8'h00);
      go;
      cpu.rw(CSR_OFS, 8'h00);
      cpu.rr(CSR_OFS, d);
      chk("csr_abort", d, 8'h02);
      cpu.rw(CSR_OFS, 8'h00);
      rdm(7'h60, ERASED);
      prog(7'h61, 8'h3C);
      go;
      wfi_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wait_run", {7'h0, eep_in_wait}, 8'h00);
      repeat (12) @(posedge clk);
      chk("wait_end", {7'h0, eep_in_wait}, 8'h01);
      wfi_req <= 1'b0;
      repeat (2) @(posedge clk);
      rdm(7'h61, 8'h3C);
      wfi_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk("wait_idle", {7'h0, eep_in_wait}, 8'h01);
      wfi_req <= 1'b0;
      repeat (2) @(posedge clk);
      prog(7'h62, 8'h00);
      go;
      halt_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk("halt", {7'h0, eep_in_halt}, 8'h01);
      halt_req <= 1'b0;
      repeat (2) @(posedge clk);
      cpu.rr(CSR_OFS, d);
      chk("csr_halt", d, 8'h00);
      rdm(7'h62, ERASED);
      prog(7'h63, 8'h00);
      go;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      cpu.rr(CSR_OFS, d);
      chk("csr_rst2", d, 8'h00);
      tally_and_finish;
   end
endmodule
